// *** design/efg_governor.v ***
`timescale 1ns/10ps
`default_nettype none
`include "efg_regs.vh"
module efg_governor #(
   parameter [31:0] HOLD_CYCLES = `EFG_HOLD_MS * `EFG_CLK_KHZ
) (
   // Clock and reset
   input  wire        clk,
   input  wire        reset,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Speed sensors and torsion level, 16-bit words from the sensor front end
   input  wire [15:0] speedA,
   input  wire [15:0] speedB,
   input  wire [15:0] torsionLevel,
   // Discrete inputs
   input  wire        runPermitInput,
   input  wire        alternateTuningSelect,
   input  wire        speedFailOverride,
   input  wire        bumpRequest,
   // Outputs
   output reg  [15:0] fuelDemand,
   output reg         torsionAlarm,
   output reg         torsionShutdown,
   output reg         notchActive
);
   localparam ST_ARMED = 3'b001;
   localparam ST_CAPPED = 3'b010;
   localparam ST_FREE = 3'b100;

   function [15:0] pctOf;
      input [15:0] val;
      input [15:0] pct;
      reg   [31:0] p;
      reg   [31:0] q;
      begin
         p = val * pct;
         q = p / 32'd100;
         pctOf = q[15:0];
      end
   endfunction

   function [15:0] mulQ;
      input [15:0] a;
      input [15:0] b;
      reg   [31:0] p;
      begin
         p = a * b;
         mulQ = (p[31:24] != 8'h00) ? `EFG_FULL : p[23:8];
      end
   endfunction

   function [15:0] divQ;
      input [15:0] a;
      input [15:0] b;
      reg   [31:0] q;
      begin
         q = (b == 16'h0000) ? 32'h00000000 : ({a, 8'h00} / {16'h0000, b});
         divQ = (q[31:16] != 16'h0000) ? `EFG_FULL : q[15:0];
      end
   endfunction

   function [15:0] min2;
      input [15:0] a;
      input [15:0] b;
      begin
         min2 = (a < b) ? a : b;
      end
   endfunction

   // Two-flop synchronisers for discrete pins
   reg [3:0] dinMeta;
   reg [3:0] dinSync;
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         dinMeta <= 4'h0;
         dinSync <= 4'h0;
      end else begin
         dinMeta <= {bumpRequest, speedFailOverride, alternateTuningSelect, runPermitInput};
         dinSync <= dinMeta;
      end
   end
   wire runOk = dinSync[0];
   wire altSel = dinSync[1];
   wire failOvrd = dinSync[2];
   wire bumpPin = dinSync[3];

   // Registers
   reg [7:0]  ctrl;
   reg [15:0] ratedSpeed;
   reg [31:0] tune0;
   reg [31:0] tune1;
   reg [31:0] winReg;
   reg [31:0] limitReg;
   reg [31:0] startReg;
   reg [31:0] bumpReg;
   reg [31:0] mapFuelLo;
   reg [31:0] mapFuelHi;
   reg [31:0] mapGainLo;
   reg [31:0] mapGainHi;
   reg [31:0] torsReg;
   reg [15:0] speedRef;

   // Speed selection
   wire failA = speedA < pctOf(ratedSpeed, `EFG_FAIL_PCT);
   wire failB = speedB < pctOf(ratedSpeed, `EFG_FAIL_PCT);
   wire coupOn = ctrl[`EFG_CTRL_COUPSEL] && ctrl[`EFG_CTRL_COUPEN] && !failA && !failB;
   wire [15:0] hiSpeed = (speedA > speedB) ? speedA : speedB;
   // Mean of both pickups, carry kept
   wire [16:0] avgSum = {1'b0, speedA} + {1'b0, speedB};
   wire [15:0] avgSpeed = avgSum[16:1];
   wire [15:0] rawSpeed = coupOn ? avgSpeed : hiSpeed;
   wire notchOn = ctrl[`EFG_CTRL_NOTCH] && ctrl[`EFG_CTRL_COUPSEL] && ctrl[`EFG_CTRL_COUPEN];
   reg  [15:0] filtSpeed;
   wire [15:0] speed = (coupOn || notchOn) ? filtSpeed : rawSpeed;

   // Tuning set select
   wire [31:0] tune = altSel ? tune1 : tune0;
   wire [15:0] baseGain = tune[15:0];
   wire [15:0] baseReset = tune[31:16];
   wire [15:0] slope = altSel ? {8'h00, winReg[31:24]} : {8'h00, winReg[23:16]};
   wire [15:0] window = winReg[15:0];
   wire [7:0]  gainRatio = altSel ? torsReg[31:24] : torsReg[23:16];

   // Load gain map
   reg [15:0] mapGain;
   integer i;
   reg [15:0] fx0, fx1, gy0, gy1;
   always @* begin
      mapGain = mapGainHi[31:16];
      fx0 = 16'h0000;
      fx1 = 16'h0000;
      gy0 = 16'h0000;
      gy1 = 16'h0000;
      if (fuelDemand <= {mapFuelLo[7:0], 8'h00}) begin
         mapGain = {mapGainLo[7:0], 8'h00};
      end else begin
         for (i = 0; i < 4; i = i + 1) begin
            fx0 = (i < 3) ? {mapFuelLo[i*8 +: 8], 8'h00} : {mapFuelLo[31:24], 8'h00};
            fx1 = (i < 3) ? {mapFuelLo[i*8+8 +: 8], 8'h00} : {mapFuelHi[7:0], 8'h00};
            gy0 = (i < 3) ? {mapGainLo[i*8 +: 8], 8'h00} : {mapGainLo[31:24], 8'h00};
            gy1 = (i < 3) ? {mapGainLo[i*8+8 +: 8], 8'h00} : {mapGainHi[7:0], 8'h00};
            if (fuelDemand > fx0 && fuelDemand <= fx1)
               mapGain = (gy1 >= gy0) ?
                  gy0 + mulQ(gy1 - gy0, divQ(fuelDemand - fx0, fx1 - fx0)) :
                  gy0 - mulQ(gy0 - gy1, divQ(fuelDemand - fx0, fx1 - fx0));
         end
      end
   end

   // Gain scheduling
   wire [15:0] varFactor = divQ(speed, ratedSpeed);
   wire [15:0] gainSrc = ctrl[`EFG_CTRL_USEMAP] ? mapGain : baseGain;
   wire [15:0] brk = {limitReg[31:24], 8'h00};
   wire slopeOn = !ctrl[`EFG_CTRL_USEMAP] && (slope != 16'h0000);
   wire [15:0] slopeAdd = (slopeOn && fuelDemand > brk) ? mulQ(fuelDemand - brk, slope) : 16'h0000;
   wire [16:0] slopedSum = {1'b0, gainSrc} + {1'b0, slopeAdd};
   wire [15:0] sloped = slopedSum[16] ? `EFG_FULL : slopedSum[15:0];
   wire [15:0] schedGain = ctrl[`EFG_CTRL_VARTUNE] ? mulQ(sloped, varFactor) : sloped;
   wire [15:0] schedReset = ctrl[`EFG_CTRL_VARTUNE] ? mulQ(baseReset, divQ(ratedSpeed, speed)) : baseReset;
   wire signed [16:0] spdErr = $signed({1'b0, speedRef}) - $signed({1'b0, speed});
   wire [16:0] errMag = spdErr[16] ? -spdErr : spdErr;
   wire [15:0] loopGain = (errMag > {1'b0, window}) ? mulQ(schedGain, {gainRatio, 8'h00}) : schedGain;

   // Bump disturbance
   reg  [15:0] bumpCnt;
   reg         bumpPrev;
   wire        bumpAct = bumpCnt != 16'h0000;

   // PI loop
   reg signed [31:0] integ;
   wire signed [31:0] pTerm = $signed(spdErr) * $signed({1'b0, loopGain});
   wire signed [31:0] iStep = ($signed(spdErr) * $signed({1'b0, schedReset})) >>> 8;
   wire signed [31:0] piSum = integ + (pTerm >>> 8);
   wire [15:0] piOut = piSum[31] ? 16'h0000 : (piSum[31:16] != 16'h0000 ? `EFG_FULL : piSum[15:0]);
   wire [16:0] bumpSum = {1'b0, piOut} + (bumpAct ? {1'b0, bumpReg[15:0]} : 17'h00000);
   wire [15:0] loopOut = bumpSum[16] ? `EFG_FULL : bumpSum[15:0];

   // Limits
   reg  [2:0]  startState;
   reg  [15:0] startCap;
   reg  [31:0] holdCnt;
   reg  [31:0] rampDly;
   wire bothFail = failA && failB;
   wire minFuel = !runOk || (bothFail && !failOvrd);
   wire torsHigh = coupOn && (torsionLevel > torsReg[15:0]);
   wire [15:0] maxLim = limitReg[15:0];
   wire [15:0] torsLim = torsHigh ? bumpReg[31:16] : `EFG_FULL;
   wire [15:0] loopSel = (bothFail && failOvrd) ? `EFG_FULL : loopOut;
   wire [15:0] capUse = (startReg[15:0] == `EFG_FULL) ? `EFG_FULL : startCap;
   wire [15:0] next_fuel = minFuel ? 16'h0000 : min2(min2(loopSel, maxLim), min2(torsLim, capUse));
   wire inControl = !minFuel && (next_fuel == loopSel) && (loopSel < capUse);
   wire trigSpeed = speed >= pctOf(ratedSpeed, `EFG_TRIG_PCT);

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         startState <= ST_ARMED;
         startCap <= `EFG_FULL;
         holdCnt <= 32'h00000000;
         rampDly <= 32'h00000000;
      end else begin
         case (startState)
            ST_ARMED: begin
               startCap <= `EFG_FULL;
               if (trigSpeed && runOk) begin
                  startState <= ST_CAPPED;
                  startCap <= startReg[15:0];
                  rampDly <= 32'h00000000;
                  holdCnt <= 32'h00000000;
               end
            end
            ST_CAPPED: begin
               if (rampDly < `EFG_RAMP_DELAY)
                  rampDly <= rampDly + 32'h00000001;
               else if (startReg[31:16] != 16'h0000)
                  startCap <= min2(startCap, `EFG_FULL - startReg[31:16]) + startReg[31:16];
               if (speed >= pctOf(speedRef, `EFG_REL_PCT) && inControl)
                  holdCnt <= holdCnt + 32'h00000001;
               else
                  holdCnt <= 32'h00000000;
               if (holdCnt >= HOLD_CYCLES) begin
                  startState <= ST_FREE;
                  startCap <= `EFG_FULL;
               end
               // Any fall below trigger speed re-arms the cap
               if (!trigSpeed)
                  startState <= ST_ARMED;
            end
            ST_FREE: begin
               startCap <= `EFG_FULL;
               if (!trigSpeed)
                  startState <= ST_ARMED;
            end
            default: startState <= ST_ARMED;
         endcase
      end
   end

   // Loop state, filter, bump, outputs
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         integ <= 32'sh00000000;
         filtSpeed <= 16'h0000;
         bumpCnt <= 16'h0000;
         bumpPrev <= 1'b0;
         fuelDemand <= 16'h0000;
         torsionAlarm <= 1'b0;
         torsionShutdown <= 1'b0;
         notchActive <= 1'b0;
      end else begin
         filtSpeed <= filtSpeed + (rawSpeed >> 3) - (filtSpeed >> 3);
         bumpPrev <= bumpPin | ctrl[`EFG_CTRL_BUMP];
         if ((bumpPin | ctrl[`EFG_CTRL_BUMP]) && !bumpPrev)
            bumpCnt <= {4'h0, limitReg[23:16], 4'h0};
         else if (bumpAct)
            bumpCnt <= bumpCnt - 16'h0001;
         if (minFuel)
            integ <= 32'sh00000000;
         else if (!((piOut == `EFG_FULL && !iStep[31]) || (piOut == 16'h0000 && iStep[31])))
            integ <= integ + iStep;
         fuelDemand <= next_fuel;
         torsionAlarm <= torsHigh && torsReg[14];
         torsionShutdown <= torsHigh && torsReg[15];
         notchActive <= notchOn;
      end
   end

   // APB slave, zero wait
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrl <= 8'h00;
         ratedSpeed <= 16'h0000;
         tune0 <= 32'h00000000;
         tune1 <= 32'h00000000;
         winReg <= 32'h00000000;
         limitReg <= 32'h0000ffff;
         startReg <= 32'h0000ffff;
         bumpReg <= 32'h00000000;
         mapFuelLo <= 32'h00000000;
         mapFuelHi <= 32'h00000000;
         mapGainLo <= 32'h00000000;
         mapGainHi <= 32'h00000000;
         torsReg <= 32'h0000ffff;
         speedRef <= 16'h0000;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            prdata <= 32'h00000000;
            case (paddr)
               `EFG_ADDR_CTRL: prdata <= {24'h000000, ctrl};
               `EFG_ADDR_RATED: prdata <= {16'h0000, ratedSpeed};
               `EFG_ADDR_TUNE0: prdata <= tune0;
               `EFG_ADDR_TUNE1: prdata <= tune1;
               `EFG_ADDR_WIN: prdata <= winReg;
               `EFG_ADDR_LIMIT: prdata <= limitReg;
               `EFG_ADDR_START: prdata <= startReg;
               `EFG_ADDR_BUMP: prdata <= bumpReg;
               `EFG_ADDR_MAPF: prdata <= mapFuelLo;
               `EFG_ADDR_MAPG: prdata <= mapGainLo;
               `EFG_ADDR_TORS: prdata <= torsReg;
               `EFG_ADDR_SPDREF: prdata <= {16'h0000, speedRef};
               `EFG_ADDR_STATUS: prdata <= {24'h000000, startState, bothFail, failB, failA, coupOn, torsHigh};
               `EFG_ADDR_FUEL: prdata <= {16'h0000, fuelDemand};
               `EFG_ADDR_SPEED: prdata <= {16'h0000, speed};
               default: pslverr <= 1'b0;
            endcase
         end
         // Writes land at the access edge
         if (psel && penable && pready && pwrite) begin
            begin
               case (paddr)
                  `EFG_ADDR_CTRL: ctrl <= pwdata[7:0];
                  `EFG_ADDR_RATED: ratedSpeed <= pwdata[15:0];
                  `EFG_ADDR_TUNE0: tune0 <= pwdata;
                  `EFG_ADDR_TUNE1: tune1 <= pwdata;
                  `EFG_ADDR_WIN: winReg <= pwdata;
                  `EFG_ADDR_LIMIT: limitReg <= pwdata;
                  `EFG_ADDR_START: startReg <= pwdata;
                  `EFG_ADDR_BUMP: bumpReg <= pwdata;
                  `EFG_ADDR_MAPF: mapFuelLo <= pwdata;
                  `EFG_ADDR_MAPG: mapGainLo <= pwdata;
                  `EFG_ADDR_TORS: torsReg <= pwdata;
                  `EFG_ADDR_SPDREF: speedRef <= pwdata[15:0];
                  default: mapFuelHi <= mapFuelHi;
               endcase
            end
         end
         // Access cycle ends the answer
         if (psel && penable)
            pready <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// *** design/efg_regs.vh ***
`ifndef EFG_REGS_VH
`define EFG_REGS_VH
`define EFG_ADDR_CTRL     12'h000
`define EFG_ADDR_RATED    12'h004
`define EFG_ADDR_TUNE0    12'h008
`define EFG_ADDR_TUNE1    12'h00c
`define EFG_ADDR_WIN      12'h010
`define EFG_ADDR_LIMIT    12'h014
`define EFG_ADDR_START    12'h018
`define EFG_ADDR_BUMP     12'h01c
`define EFG_ADDR_MAPF     12'h020
`define EFG_ADDR_MAPG     12'h024
`define EFG_ADDR_TORS     12'h028
`define EFG_ADDR_SPDREF   12'h02c
`define EFG_ADDR_STATUS   12'h030
`define EFG_ADDR_FUEL     12'h034
`define EFG_ADDR_SPEED    12'h038
`define EFG_CTRL_VARTUNE  0
`define EFG_CTRL_USEMAP   1
`define EFG_CTRL_COUPSEL  2
`define EFG_CTRL_COUPEN   3
`define EFG_CTRL_NOTCH    4
`define EFG_CTRL_BUMP     5
`define EFG_FULL          16'hffff
`define EFG_TRIG_PCT      16'h0005
`define EFG_FAIL_PCT      16'h0005
`define EFG_REL_PCT       16'h005f
`define EFG_HOLD_MS       32'h000003e8
`define EFG_CLK_KHZ       32'h0000c350
`define EFG_RAMP_DELAY    32'h00000010
`endif

// *** test/efg_governor_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module efg_governor_bench;
   typedef struct packed {logic [15:0] a; logic [15:0] b; logic [5:0] ctrl; logic [3:0] st; logic [15:0] spd; logic nt;} efg_row_t;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] rd;
   logic        runPermitInput = 1'b0;
   logic        speedFailOverride = 1'b0;
   logic [15:0] wantA = 16'h03e8;
   logic [15:0] wantB = 16'h03e8;
   wire  [31:0] prdata;
   wire         pready, pslverr, torsionAlarm, torsionShutdown, notchActive;
   wire  [15:0] speedA, speedB, fuelDemand;
   int          n_mismatch = 0;
   int          total_checks = 0;
   // Speeds, control bits, status bits 4:1, selected speed (ffff skips), notch
   efg_row_t rows [12] = '{
      '{16'd800, 16'd900, 6'h00, 4'h0, 16'd900, 1'b0}, '{16'd900, 16'd800, 6'h00, 4'h0, 16'd900, 1'b0},
      '{16'd40, 16'd900, 6'h00, 4'h2, 16'd900, 1'b0}, '{16'd900, 16'd49, 6'h00, 4'h4, 16'd900, 1'b0},
      '{16'd50, 16'd51, 6'h00, 4'h0, 16'd51, 1'b0}, '{16'd30, 16'd20, 6'h00, 4'he, 16'd30, 1'b0},
      '{16'd900, 16'd800, 6'h0c, 4'h1, 16'hffff, 1'b0}, '{16'd40, 16'd900, 6'h0c, 4'h2, 16'd900, 1'b0},
      '{16'd900, 16'd800, 6'h04, 4'h0, 16'd900, 1'b0}, '{16'd900, 16'd49, 6'h1c, 4'h4, 16'hffff, 1'b1},
      '{16'd900, 16'd49, 6'h14, 4'h4, 16'hffff, 1'b0}, '{16'd900, 16'd49, 6'h10, 4'h4, 16'd900, 1'b0}};
   efg_governor #(.HOLD_CYCLES(32'd20)) u_dut (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .speedA, .speedB, .torsionLevel(16'h0000), .runPermitInput,
      .alternateTuningSelect(1'b0), .speedFailOverride, .bumpRequest(1'b0), .fuelDemand, .torsionAlarm,
      .torsionShutdown, .notchActive);
   efg_sensor_model u_sens (.clk, .wantA, .wantB, .speedA, .speedB);
   always #10 clk = ~clk;
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) n_mismatch++;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic idle(input int c);
      repeat (c) @(posedge clk);
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      print_verdict();
   end
   initial begin
      @(posedge clk);
      check("fuel in reset", {16'h0, fuelDemand}, 32'h0);
      check("flags in reset", {29'h0, torsionAlarm, torsionShutdown, notchActive}, 32'h0);
      reset <= 1'b0;
      @(posedge clk);
      apb(1'b1, 12'h004, 32'h000003e8);
      apb(1'b1, 12'h02c, 32'h000003e8);
      apb(1'b1, 12'h100, 32'hdeadbeef);
      apb(1'b0, 12'h100, 32'h0);
      check("unmapped", rd, 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      check("rated", rd, 32'h000003e8);
      $display("test registers done");
      foreach (rows[i]) begin
         wantA <= rows[i].a;
         wantB <= rows[i].b;
         apb(1'b1, 12'h000, {26'h0, rows[i].ctrl});
         idle(8);
         apb(1'b0, 12'h030, 32'h0);
         check("status", rd & 32'h1e, {27'h0, rows[i].st, 1'b0});
         check("notch", {31'h0, notchActive}, {31'h0, rows[i].nt});
         apb(1'b0, 12'h038, 32'h0);
         if (rows[i].spd !== 16'hffff) check("speed", rd, {16'h0, rows[i].spd});
      end
      $display("test speed select done");
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h008, 32'h01000100);
      apb(1'b1, 12'h014, 32'h00001000);
      apb(1'b1, 12'h018, 32'h0000ffff);
      wantA <= 16'd900;
      wantB <= 16'd900;
      runPermitInput <= 1'b1;
      idle(300);
      check("fuel under ceiling", {31'h0, fuelDemand > 16'h0000 && fuelDemand <= 16'h1000}, 32'h1);
      runPermitInput <= 1'b0;
      idle(6);
      check("fuel no permit", {16'h0, fuelDemand}, 32'h0);
      $display("test ceiling done");
      apb(1'b1, 12'h014, 32'h0000ffff);
      apb(1'b1, 12'h018, 32'h00000800);
      wantA <= 16'd0;
      wantB <= 16'd0;
      runPermitInput <= 1'b1;
      idle(12);
      check("fuel both failed", {16'h0, fuelDemand}, 32'h0);
      wantA <= 16'd100;
      wantB <= 16'd100;
      idle(300);
      check("start cap", {31'h0, fuelDemand > 16'h0000 && fuelDemand <= 16'h0800}, 32'h1);
      $display("test start cap done");
      wantA <= 16'd0;
      wantB <= 16'd0;
      speedFailOverride <= 1'b1;
      idle(300);
      check("override fuel", {31'h0, fuelDemand > 16'h0000}, 32'h1);
      speedFailOverride <= 1'b0;
      idle(12);
      check("override off", {16'h0, fuelDemand}, 32'h0);
      $display("test override done");
      reset <= 1'b1;
      @(posedge clk);
      @(posedge clk);
      check("fuel second reset", {16'h0, fuelDemand}, 32'h0);
      reset <= 1'b0;
      idle(4);
      $display("test second reset done");
      print_verdict();
   end
endmodule
`default_nettype wire

// *** test/efg_governor_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module efg_governor_props (
   // Clock and reset
   input wire logic        clk,
   input wire logic        reset,
   // Bus
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Pins
   input wire logic [15:0] speedA,
   input wire logic [15:0] speedB,
   input wire logic        runPermitInput,
   input wire logic        speedFailOverride,
   input wire logic [15:0] fuelDemand
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_setup; psel && !penable; endsequence
   sequence s_off; !runPermitInput [*5]; endsequence
   sequence s_dead; (speedA == 16'h0000 && speedB == 16'h0000 && !speedFailOverride) [*8]; endsequence
   property p_setup_ready; s_setup |=> pready && penable; endproperty
   property p_ready_access; pready |-> psel && penable && $past(psel && !penable); endproperty
   property p_ready_pulse; pready |=> !pready; endproperty
   property p_no_err; pready |-> !pslverr; endproperty
   property p_rdata_hold; $past(pready) && !psel |-> $stable(prdata); endproperty
   property p_runoff_zero; s_off |-> fuelDemand == 16'h0000; endproperty
   property p_run_sync; s_off ##1 runPermitInput |-> fuelDemand == 16'h0000 ##1 fuelDemand == 16'h0000; endproperty
   property p_fail_zero; s_dead |-> fuelDemand == 16'h0000; endproperty
   a_setup_ready: assert property (p_setup_ready) else $error("no answer after setup");
   a_ready_access: assert property (p_ready_access) else $error("pready outside access");
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
   a_no_err: assert property (p_no_err) else $error("pslverr raised");
   a_rdata_hold: assert property (p_rdata_hold) else $error("prdata changed while idle");
   a_runoff_zero: assert property (p_runoff_zero) else $error("fuel not zero without permit");
   a_run_sync: assert property (p_run_sync) else $error("fuel rose before sync");
   a_fail_zero: assert property (p_fail_zero) else $error("fuel not zero with both pickups dead");
endmodule
bind efg_governor efg_governor_props u_props (
   .clk(clk), .reset(reset), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .speedA(speedA), .speedB(speedB), .runPermitInput(runPermitInput),
   .speedFailOverride(speedFailOverride), .fuelDemand(fuelDemand)
);
`default_nettype wire

// *** test/efg_sensor_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module efg_sensor_model (
   // Clock
   input  wire logic        clk,
   // Wanted pickup speeds
   input  wire logic [15:0] wantA,
   input  wire logic [15:0] wantB,
   // Speed words to the governor
   output var  logic [15:0] speedA = 16'h0000,
   output var  logic [15:0] speedB = 16'h0000
);
   // Pickups refresh once a control cycle
   always @(posedge clk) begin
      speedA <= wantA;
      speedB <= wantB;
   end
endmodule
`default_nettype wire
